// ---- core/vcmp_pkg.sv ----
// package for the comparator pair event logic: offsets, fields, codes
// assumes a 32-bit avalon-mm slave with word-aligned registers
package vcmp_pkg;
   // ----------------------------------------------------------------
   // register word offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFF_CTRL_FIRST = 4'h0;
   localparam logic [3:0] OFF_CTRL_SECOND = 4'h1;
   localparam logic [3:0] OFF_MUX_FIRST = 4'h2;
   localparam logic [3:0] OFF_MUX_SECOND = 4'h3;
   localparam logic [3:0] OFF_PINCTRL = 4'h4;
   localparam logic [3:0] OFF_SCALE = 4'h5;
   localparam logic [3:0] OFF_WINCTRL = 4'h6;
   localparam logic [3:0] OFF_STATUS = 4'h7;
   localparam logic [3:0] OFF_IRQ_EN = 4'h8;
   localparam logic [3:0] OFF_IRQ_CLR = 4'h9;
   localparam logic [3:0] OFF_CURSRC = 4'hA;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_EN_POS = 0;
   localparam int CTRL_HYS_POS = 1;
   localparam int CTRL_HS_POS = 3;
   localparam int CTRL_EDGE_POS = 6;
   localparam int WIN_MODE_POS = 2;
   localparam int WIN_EN_POS = 4;
   localparam int ST_FIRST_POS = 0;
   localparam int ST_SECOND_POS = 1;
   localparam int ST_WIN_POS = 2;
   localparam int ST_RES_POS = 4;
   localparam int ST_WSTATE_POS = 6;
   localparam int CUR_EN_POS = 0;
   localparam int CUR_PIN_POS = 1;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_REG = 8'h00;
   localparam int SCALE_W = 6;
   localparam logic [1:0] EDGE_ANY = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_RISE = 2'h3;
   localparam logic [1:0] WIN_ABOVE = 2'h0;
   localparam logic [1:0] WIN_INSIDE = 2'h1;
   localparam logic [1:0] WIN_BELOW = 2'h2;
   localparam logic [1:0] WIN_OUTSIDE = 2'h3;
   localparam logic [2:0] MUX_POS_DAC = 3'h7;
   localparam logic [2:0] MUX_NEG_DAC = 3'h5;
   localparam logic [2:0] MUX_NEG_BG = 3'h6;
   localparam logic [2:0] MUX_NEG_SCALE = 3'h7;
   // bus answer: one wait cycle
   localparam logic [0:0] BUS_WAIT_RST = 1'h1;
endpackage

// ---- core/vcmp_edge.sv ----
// one comparator channel: synchroniser, edge select, event pulse
// assumes a raw asynchronous comparator level from the analog front end
`timescale 1ns/1ps
module vcmp_edge (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // configuration
   input wire logic en_i,
   input wire logic [1:0] mode_i,
   // comparator level
   input wire logic raw_i,
   // results
   output logic level_o,
   output logic event_o
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic hit_next;

   // ----------------------------------------------------------------
   // synchroniser; first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else if (ce_i) begin
         sync1_reg <= raw_i & en_i;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_reg <= 1'b0;
      end else if (ce_i) begin
         prev_reg <= sync2_reg;
      end
   end

   always_comb begin
      case (mode_i)
         vcmp_pkg::EDGE_ANY: hit_next = sync2_reg ^ prev_reg;
         vcmp_pkg::EDGE_FALL: hit_next = prev_reg & ~sync2_reg;
         vcmp_pkg::EDGE_RISE: hit_next = sync2_reg & ~prev_reg;
         default: hit_next = 1'b0;
      endcase
   end

   // single-cycle event, independent of any interrupt enable
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         event_o <= 1'b0;
      end else if (ce_i) begin
         event_o <= hit_next & en_i;
      end else begin
         event_o <= 1'b0;
      end
   end

   assign level_o = prev_reg;

   a_event_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && en_i && mode_i == vcmp_pkg::EDGE_RISE
      && sync2_reg && !prev_reg |=> event_o)
      else $error("rising edge gave no event");
   // a level toggling every cycle may legally give back-to-back events
   a_event_width: assert property (@(posedge clk_i) disable iff (rst_i)
      event_o && $stable(sync2_reg) |=> !event_o)
      else $error("event longer than one cycle");
endmodule

// ---- core/vcmp_top.sv ----
// comparator pair event logic: registers, window, pin, current source
// assumes an avalon-mm master and an analog front end outside
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - each comparator reports one only when its positive input exceeds its negative input.
// - while enabled the result is refreshed continually, readable and sent as events.
// - an interrupt can fire on any change, on rising only or on falling only.
// - events fire on the same edge condition whether or not the interrupt is enabled.
// - the port holds two identical comparators, each with its own settings.
// - window mode joins both comparators and reports whether the input lies in range.
// - window mode raises interrupts and events for above, inside or below.
// - the positive input is chosen from port pins or converter output, the negative also from bandgap or 64-level scaler.
// - software can send the first comparator's result to a port pin.
// - a current source has an enable and a pin selection.
// - hysteresis none, small or large is chosen per comparator and passed on.
// - edge code 00 any change, 10 falling, 11 rising, 01 reserved.
// - window code 00 above, 01 inside, 10 below, 11 outside.
// - a set enable bit activates a comparator, a clear one stops it.
// - a window enable bit switches the pair into window mode.
module vcmp_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // analog front end, raw comparator levels (1 when pos > neg)
   input wire logic [1:0] cmp_raw_i,
   output logic [1:0] cmp_enable_o,
   output logic [1:0] cmp_fast_o,
   output logic [3:0] hysteresis_select_o,
   output logic [5:0] mux_pos_o,
   output logic [5:0] mux_neg_o,
   output logic [5:0] scale_o,
   // current source and output pin
   output logic cursrc_en_o,
   output logic [2:0] cursrc_pin_o,
   output logic result_pin_o,
   output logic result_pin_oe_o,
   // events and interrupt
   output logic [1:0] edge_event_o,
   output logic range_event_o,
   output logic irq_o
);
   logic [7:0] ctrl_reg [2];
   logic [5:0] mux_reg [2];
   logic pinout_reg;
   logic [5:0] scale_reg;
   logic [4:0] win_reg;
   logic [3:0] cur_reg;
   logic [2:0] status_reg;
   logic [2:0] irq_en_reg;
   logic [1:0] level;
   logic [1:0] edge_hit;
   logic [1:0] wstate;
   logic [1:0] wstate_prev_reg;
   logic win_cond;
   logic win_hit;
   logic bus_pending_reg;
   logic wr_go;
   logic [2:0] clr_bits;

   // ----------------------------------------------------------------
   // two comparator channels
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         vcmp_edge u_edge (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .en_i(ctrl_reg[gi][vcmp_pkg::CTRL_EN_POS]),
            .mode_i(ctrl_reg[gi][vcmp_pkg::CTRL_EDGE_POS +: 2]),
            .raw_i(cmp_raw_i[gi]),
            .level_o(level[gi]),
            .event_o(edge_hit[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // bus slave: one wait cycle per access
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus_pending_reg <= 1'b0;
      end else if (ce_i) begin
         bus_pending_reg <= (avs_read_i | avs_write_i) & ~bus_pending_reg;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= vcmp_pkg::BUS_WAIT_RST;
      end else if (ce_i) begin
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i)
            & ~bus_pending_reg);
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // access completes on the edge where waitrequest is seen low
   assign wr_go = ce_i & avs_write_i & ~avs_waitrequest_o;
   assign clr_bits = (wr_go && avs_address_i == vcmp_pkg::OFF_IRQ_CLR) ?
      avs_writedata_i[2:0] : 3'h0;

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg[0] <= vcmp_pkg::RST_REG;
         ctrl_reg[1] <= vcmp_pkg::RST_REG;
         mux_reg[0] <= 6'h00;
         mux_reg[1] <= 6'h00;
         pinout_reg <= 1'b0;
         scale_reg <= 6'h00;
         win_reg <= 5'h00;
         cur_reg <= 4'h0;
         irq_en_reg <= 3'h0;
      end else if (wr_go) begin
         case (avs_address_i)
            vcmp_pkg::OFF_CTRL_FIRST: ctrl_reg[0] <= avs_writedata_i[7:0];
            vcmp_pkg::OFF_CTRL_SECOND: ctrl_reg[1] <= avs_writedata_i[7:0];
            vcmp_pkg::OFF_MUX_FIRST: mux_reg[0] <= avs_writedata_i[5:0];
            vcmp_pkg::OFF_MUX_SECOND: mux_reg[1] <= avs_writedata_i[5:0];
            vcmp_pkg::OFF_PINCTRL: pinout_reg <= avs_writedata_i[0];
            vcmp_pkg::OFF_SCALE: scale_reg <= avs_writedata_i[5:0];
            vcmp_pkg::OFF_WINCTRL: win_reg <= avs_writedata_i[4:0];
            vcmp_pkg::OFF_CURSRC: cur_reg <= avs_writedata_i[3:0];
            vcmp_pkg::OFF_IRQ_EN: irq_en_reg <= avs_writedata_i[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // window logic: first is upper, second is lower threshold
   // ----------------------------------------------------------------
   // wstate: 00 above, 01 inside, 10 below; 11 cannot occur in range
   always_comb begin
      if (level[0] && !level[1]) begin
         wstate = vcmp_pkg::WIN_INSIDE;
      end else if (!level[0]) begin
         wstate = vcmp_pkg::WIN_ABOVE;
      end else begin
         wstate = vcmp_pkg::WIN_BELOW;
      end
   end

   always_comb begin
      case (win_reg[vcmp_pkg::WIN_MODE_POS +: 2])
         vcmp_pkg::WIN_ABOVE: win_cond = wstate == vcmp_pkg::WIN_ABOVE;
         vcmp_pkg::WIN_INSIDE: win_cond = wstate == vcmp_pkg::WIN_INSIDE;
         vcmp_pkg::WIN_BELOW: win_cond = wstate == vcmp_pkg::WIN_BELOW;
         vcmp_pkg::WIN_OUTSIDE: win_cond = wstate != vcmp_pkg::WIN_INSIDE;
         default: win_cond = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wstate_prev_reg <= 2'h3;
      end else if (ce_i) begin
         wstate_prev_reg <= wstate;
      end
   end

   // fires on each change of wstate to a state of the chosen region, not every cycle within it
   assign win_hit = win_reg[vcmp_pkg::WIN_EN_POS]
      & (ctrl_reg[0][vcmp_pkg::CTRL_EN_POS])
      & (ctrl_reg[1][vcmp_pkg::CTRL_EN_POS])
      & win_cond & (wstate != wstate_prev_reg);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         range_event_o <= 1'b0;
         edge_event_o <= 2'h0;
      end else begin
         range_event_o <= ce_i & win_hit;
         edge_event_o <= edge_hit;
      end
   end

   // ----------------------------------------------------------------
   // sticky status and interrupt; set beats clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_reg <= 3'h0;
      end else if (ce_i) begin
         status_reg <= (status_reg & ~clr_bits)
            | {win_hit, edge_hit};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(status_reg & irq_en_reg);
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (ce_i && (avs_read_i & ~bus_pending_reg)) begin
         case (avs_address_i)
            vcmp_pkg::OFF_CTRL_FIRST: avs_readdata_o <= {24'h0, ctrl_reg[0]};
            vcmp_pkg::OFF_CTRL_SECOND: avs_readdata_o <= {24'h0, ctrl_reg[1]};
            vcmp_pkg::OFF_MUX_FIRST: avs_readdata_o <= {26'h0, mux_reg[0]};
            vcmp_pkg::OFF_MUX_SECOND: avs_readdata_o <= {26'h0, mux_reg[1]};
            vcmp_pkg::OFF_PINCTRL: avs_readdata_o <= {31'h0, pinout_reg};
            vcmp_pkg::OFF_SCALE: avs_readdata_o <= {26'h0, scale_reg};
            vcmp_pkg::OFF_WINCTRL: avs_readdata_o <= {27'h0, win_reg};
            vcmp_pkg::OFF_STATUS: avs_readdata_o <= {24'h0, wstate,
               level, 1'b0, status_reg};
            vcmp_pkg::OFF_IRQ_EN: avs_readdata_o <= {29'h0, irq_en_reg};
            vcmp_pkg::OFF_CURSRC: avs_readdata_o <= {28'h0, cur_reg};
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // analog front end controls and pins
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_enable_o <= 2'h0;
         cmp_fast_o <= 2'h0;
         hysteresis_select_o <= 4'h0;
         mux_pos_o <= 6'h00;
         mux_neg_o <= 6'h00;
         scale_o <= 6'h00;
         cursrc_en_o <= 1'b0;
         cursrc_pin_o <= 3'h0;
         result_pin_o <= 1'b0;
         result_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         cmp_enable_o <= {ctrl_reg[1][0], ctrl_reg[0][0]};
         cmp_fast_o <= {ctrl_reg[1][vcmp_pkg::CTRL_HS_POS],
            ctrl_reg[0][vcmp_pkg::CTRL_HS_POS]};
         hysteresis_select_o <= {ctrl_reg[1][2:1], ctrl_reg[0][2:1]};
         mux_pos_o <= {mux_reg[1][5:3], mux_reg[0][5:3]};
         mux_neg_o <= {mux_reg[1][2:0], mux_reg[0][2:0]};
         scale_o <= scale_reg;
         cursrc_en_o <= cur_reg[vcmp_pkg::CUR_EN_POS];
         cursrc_pin_o <= cur_reg[vcmp_pkg::CUR_PIN_POS +: 3];
         result_pin_o <= level[0];
         result_pin_oe_o <= pinout_reg;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && |(status_reg & irq_en_reg) |=> irq_o)
      else $error("enabled status without interrupt");
   a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !(|(status_reg & irq_en_reg)) |=> !irq_o)
      else $error("interrupt without enabled status");
   a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && edge_hit[0] |=> status_reg[0])
      else $error("edge event lost from status");
   a_win_inside: assert property (@(posedge clk_i) disable iff (rst_i)
      level == 2'b01 |-> wstate == vcmp_pkg::WIN_INSIDE)
      else $error("window state wrong");
   a_win_event: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && win_hit |=> range_event_o ##1 !range_event_o)
      else $error("window event not one pulse");
   a_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && pinout_reg |=> result_pin_oe_o
      && result_pin_o == $past(level[0]))
      else $error("result pin not driven");
   a_disabled_quiet: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!ctrl_reg[0][0]) [*4] |-> !edge_hit[0])
      else $error("disabled comparator gave event");
   a_cursrc: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> cursrc_en_o == $past(cur_reg[0]))
      else $error("current source enable wrong");
   a_hys_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> hysteresis_select_o[1:0] == $past(ctrl_reg[0][2:1]))
      else $error("hysteresis not passed");
   c_edge_irq: cover property (@(posedge clk_i) edge_hit[0] ##[1:3] irq_o);
   c_window: cover property (@(posedge clk_i) range_event_o);
   c_both: cover property (@(posedge clk_i) edge_hit == 2'b11);
endmodule

// ---- tb/vcmp_afe_model.sv ----
// analog front end model: two comparators behind their input multiplexers
// assumes the bench drives port pin, converter and bandgap levels in mV
`timescale 1ns/1ps
module vcmp_afe_model #(
   parameter int VCC_MV = 3300
) (
   // levels in millivolts
   input wire logic [7:0][11:0] pin_mv_i,
   input wire logic [11:0] dac_mv_i,
   input wire logic [11:0] bg_mv_i,
   // settings from the block
   input wire logic [1:0] cmp_enable_i,
   input wire logic [5:0] mux_pos_i,
   input wire logic [5:0] mux_neg_i,
   input wire logic [5:0] scale_i,
   // raw results
   output logic [1:0] cmp_raw_o
);
   // ----------------------------------------------------------------
   // input selection and compare
   // ----------------------------------------------------------------
   int pv [2];
   int nv [2];
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pv[i] = (mux_pos_i[3*i+:3] == 3'h7) ? int'(dac_mv_i) :
            int'(pin_mv_i[mux_pos_i[3*i+:3]]);
         case (mux_neg_i[3*i+:3])
            3'h0: nv[i] = int'(pin_mv_i[0]);
            3'h1: nv[i] = int'(pin_mv_i[1]);
            3'h2: nv[i] = int'(pin_mv_i[3]);
            3'h3: nv[i] = int'(pin_mv_i[5]);
            3'h4: nv[i] = int'(pin_mv_i[7]);
            3'h5: nv[i] = int'(dac_mv_i);
            3'h6: nv[i] = int'(bg_mv_i);
            default: nv[i] = VCC_MV * (int'(scale_i) + 1) / 64;
         endcase
         // equal levels give zero, a stopped comparator gives zero
         cmp_raw_o[i] = cmp_enable_i[i] && (pv[i] > nv[i]);
      end
   end
endmodule

// ---- tb/vcmp_top_tb_top.sv ----
// bench for the comparator pair: bus tasks, edge, window, source scenarios
// assumes vcmp_top and the front end model; ce_i held high throughout
`timescale 1ns/1ps
module vcmp_top_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, d;
   logic wait_req, cs_en, pin_o, pin_oe, rng_ev, irq;
   logic [1:0] raw, en, fast, edge_ev;
   logic [3:0] hys;
   logic [5:0] mpos, mneg, scale;
   logic [2:0] cs_pin;
   logic [7:0][11:0] pin_mv = '0;
   logic [11:0] dac_mv = 12'h0;
   logic [11:0] bg_mv = 12'h3E8;
   logic [2:0] ev_now;
   logic [2:0] ev_prev = 3'h0;
   int ev_cnt [3];
   int dbl, cyc, errors, n_checks;
   // ----------------------------------------------------------------
   // clock, instances, event counters
   // ----------------------------------------------------------------
   always #12.5 clk_i = ~clk_i;
   vcmp_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_req), .cmp_raw_i(raw), .cmp_enable_o(en),
      .cmp_fast_o(fast), .hysteresis_select_o(hys), .mux_pos_o(mpos),
      .mux_neg_o(mneg), .scale_o(scale), .cursrc_en_o(cs_en),
      .cursrc_pin_o(cs_pin), .result_pin_o(pin_o),
      .result_pin_oe_o(pin_oe), .edge_event_o(edge_ev),
      .range_event_o(rng_ev), .irq_o(irq));
   vcmp_afe_model afe (.pin_mv_i(pin_mv), .dac_mv_i(dac_mv),
      .bg_mv_i(bg_mv), .cmp_enable_i(en), .mux_pos_i(mpos),
      .mux_neg_i(mneg), .scale_i(scale), .cmp_raw_o(raw));
   assign ev_now = {rng_ev, edge_ev};
   always @(posedge clk_i) begin
      for (int i = 0; i < 3; i++) begin
         if (ev_now[i] === 1'b1)
            ev_cnt[i]++;
      end
      // a pulse seen on two edges in a row counts as a fault
      if ((ev_now & ev_prev) !== 3'h0)
         dbl++;
      ev_prev <= ev_now;
      cyc++;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] v);
      int t;
      t = 0;
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk_i);
         t++;
      end while (wait_req !== 1'b0 && t < 50);
      if (wait_req !== 1'b0)
         errors++;
      d = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic settle();
      repeat (8) @(posedge clk_i);
   endtask
   task automatic set_sig(input logic [11:0] v);
      @(posedge clk_i);
      pin_mv[0] <= v;
      settle();
   endtask
   // sticky flag, masked and enabled interrupt, write-one clear
   task automatic irq_cycle(input int b);
      bus(1'b0, vcmp_pkg::OFF_STATUS, 32'h0);
      chk("status flag", 32'(d[b]), 32'h1);
      chk("irq masked", 32'(irq), 32'h0);
      bus(1'b1, vcmp_pkg::OFF_IRQ_EN, 32'h1 << b);
      settle();
      chk("irq on", 32'(irq), 32'h1);
      bus(1'b1, vcmp_pkg::OFF_IRQ_CLR, 32'h1 << b);
      settle();
      chk("irq cleared", 32'(irq), 32'h0);
      bus(1'b1, vcmp_pkg::OFF_IRQ_EN, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic reset_map();
      chk("wait rest", 32'(wait_req), 32'h1);
      bus(1'b1, 4'hB, 32'hFF);
      for (int a = 0; a < 16; a++) begin
         bus(1'b0, 4'(a), 32'h0);
         chk("reset read", d, 32'h0);
      end
   endtask
   task automatic settings();
      bus(1'b1, vcmp_pkg::OFF_MUX_FIRST, 32'h08);
      bus(1'b1, vcmp_pkg::OFF_MUX_SECOND, 32'h10);
      bus(1'b1, vcmp_pkg::OFF_SCALE, 32'h2A);
      bus(1'b1, vcmp_pkg::OFF_CURSRC, 32'h0B);
      bus(1'b1, vcmp_pkg::OFF_PINCTRL, 32'h1);
      bus(1'b1, vcmp_pkg::OFF_CTRL_FIRST, 32'h0B);
      bus(1'b1, vcmp_pkg::OFF_CTRL_SECOND, 32'h05);
      settle();
      chk("enable", 32'(en), 32'h3);
      chk("fast", 32'(fast), 32'h1);
      chk("hysteresis", 32'(hys), 32'h9);
      chk("mux", 32'({mpos, mneg}), 32'h440);
      chk("scale", 32'(scale), 32'h2A);
      chk("cursrc", 32'({cs_pin, cs_en}), 32'hB);
      chk("pin oe", 32'(pin_oe), 32'h1);
      bus(1'b0, vcmp_pkg::OFF_CTRL_FIRST, 32'h0);
      chk("ctrl read", d, 32'h0B);
   endtask
   // converter, bandgap and scaler inputs, result shown on the pin
   task automatic sources();
      logic [7:0] mx [4];
      logic [11:0] dv [4];
      logic [5:0] sc [4];
      mx = '{8'h3E, 8'h3E, 8'h0F, 8'h0F};
      dv = '{12'h4B0, 12'h320, 12'h0, 12'h0};
      sc = '{6'h0, 6'h0, 6'h1F, 6'h3F};
      pin_mv[1] <= 12'h7D0;
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, vcmp_pkg::OFF_CTRL_FIRST, 32'h0);
         bus(1'b1, vcmp_pkg::OFF_MUX_FIRST, 32'(mx[k]));
         bus(1'b1, vcmp_pkg::OFF_SCALE, 32'(sc[k]));
         dac_mv <= dv[k];
         bus(1'b1, vcmp_pkg::OFF_CTRL_FIRST, 32'h0B);
         settle();
         bus(1'b0, vcmp_pkg::OFF_STATUS, 32'h0);
         chk("src level", 32'(d[4]), 32'(k % 2 == 0));
         chk("pin level", 32'(pin_o), 32'(k % 2 == 0));
      end
      bus(1'b1, vcmp_pkg::OFF_CTRL_FIRST, 32'h0);
      bus(1'b1, vcmp_pkg::OFF_MUX_FIRST, 32'h08);
   endtask
   task automatic edge_modes(input int ch);
      logic [11:0] v1, v0;
      logic [1:0] md;
      int c;
      v1 = ch ? 12'h1F4 : 12'h5DC;
      v0 = ch ? 12'h5DC : 12'h9C4;
      for (int m = 0; m < 4; m++) begin
         md = 2'(m);
         set_sig(v0);
         bus(1'b1, 4'(ch), 32'h1 | (32'(md) << vcmp_pkg::CTRL_EDGE_POS));
         settle();
         c = ev_cnt[ch];
         set_sig(v1);
         chk("rise events", 32'(ev_cnt[ch] - c), 32'(md ==
            vcmp_pkg::EDGE_ANY || md == vcmp_pkg::EDGE_RISE));
         bus(1'b0, vcmp_pkg::OFF_STATUS, 32'h0);
         chk("level", 32'(d[vcmp_pkg::ST_RES_POS + ch]), 32'h1);
         c = ev_cnt[ch];
         set_sig(v0);
         chk("fall events", 32'(ev_cnt[ch] - c), 32'(md ==
            vcmp_pkg::EDGE_ANY || md == vcmp_pkg::EDGE_FALL));
      end
      irq_cycle(ch);
   endtask
   task automatic window_modes();
      logic [11:0] path [5];
      logic [1:0] st [5];
      logic [1:0] md;
      int c, ex;
      path = '{12'h1F4, 12'h5DC, 12'h9C4, 12'h5DC, 12'h1F4};
      st = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h2};
      bus(1'b1, vcmp_pkg::OFF_CTRL_FIRST, 32'h1);
      bus(1'b1, vcmp_pkg::OFF_CTRL_SECOND, 32'h1);
      for (int m = 0; m < 4; m++) begin
         md = 2'(m);
         set_sig(path[0]);
         bus(1'b1, vcmp_pkg::OFF_WINCTRL, 32'h10 | (32'(md) << 2));
         settle();
         c = ev_cnt[2];
         ex = 0;
         for (int k = 1; k < 5; k++) begin
            set_sig(path[k]);
            bus(1'b0, vcmp_pkg::OFF_STATUS, 32'h0);
            chk("window state", 32'(d[7:6]), 32'(st[k]));
            if (md == 2'h3 ? (st[k] != 2'h1 && st[k-1] == 2'h1) :
               (st[k] == md && st[k-1] != md))
               ex++;
         end
         chk("window events", 32'(ev_cnt[2] - c), 32'(ex));
      end
      irq_cycle(2);
   endtask
   // ----------------------------------------------------------------
   // sequence and verdict
   // ----------------------------------------------------------------
   task automatic results();
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      pin_mv[1] = 12'h7D0;
      pin_mv[2] = 12'h3E8;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_map();
      settings();
      sources();
      edge_modes(0);
      edge_modes(1);
      window_modes();
      bus(1'b1, vcmp_pkg::OFF_CTRL_FIRST, 32'h0);
      settle();
      chk("disabled", 32'(en[0]), 32'h0);
      chk("single pulses", 32'(dbl), 32'h0);
      results();
   end
endmodule
